// ---- hdl/rit_top.sv ----
// Behaviour
// RULE1: reset zeroes both direction and both output registers; all port pins input.
// RULE2: during reset the data bus is not driven and interrupts are off.
// RULE3: the host holds reset low for at least one clock period.
// RULE4: read/write high reads the selected location, low writes it.
// RULE5: interrupt request is open drain, pulled low only for an enabled interrupt.
// RULE6: interrupt sources are a port A top bit edge and timer expiry.
// RULE7: data bus is driven only for a read addressed to this block.
// RULE8: direction bit 1 makes a pin output carrying its output register bit.
// RULE9: port A data read returns the pin levels, even for outputs.
// RULE10: port B data read returns the stored output register.
// RULE11: a 128 byte RAM is selected by address, RAM select and chip selects.
// RULE12: timer write loads the count and picks prescale 1, 8, 64 or 1024.
// RULE13: every timer read or write latches address line three as timer enable.
// RULE14: timeout sets interrupt flag bit 7 regardless of the enable.
// RULE15: timer read or write clears the flag, but not in the timeout cycle.
// RULE16: before timeout a read gives intervals left, one step per interval.
// RULE17: from zero the next step raises the timeout and wraps to all ones.
// RULE18: after timeout the count drops every clock, reading negated elapsed time.
// RULE19: sixteen pins in two byte ports; port A top pin is an interrupt input.
// RULE20: RAM select low picks RAM; else address two picks timer or ports.
// RULE21: reading the flag register clears the edge flag held in bit 6.
// RULE22: reset disables the edge interrupt, picks falling edge, edge may still flag.
// RULE23: a timer write restarts the prescaler; timeout after count times prescale plus one.
`timescale 1ns/1ps
module rit_top #(
    parameter int RAM_DEPTH = rit_pkg::RAM_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rw_i,
    input wire logic [rit_pkg::ADDR_W-1:0] addr_i,
    input wire logic ram_io_select_n_i,
    input wire logic chip_select_hi_i,
    input wire logic chip_select_lo_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic irq_o,
    output logic irq_oe_o,
    input wire logic [7:0] porta_pins_i,
    output logic [7:0] porta_pins_o,
    output logic [7:0] porta_oe_o,
    output logic [7:0] portb_pins_o,
    output logic [7:0] portb_oe_o
);
    logic [7:0] mem [RAM_DEPTH];
    logic [7:0] port_a_direction_r;
    logic [7:0] port_b_direction_r;
    logic [7:0] port_a_output_r;
    logic [7:0] port_b_output_r;
    logic timer_irq_enable_r;
    logic edge_irq_enable_r;
    logic edge_pos_r;
    logic edge_flag_r;
    logic porta_top_prev_r;
    logic [7:0] data_r;
    logic data_oe_r;
    logic [7:0] rd_val;
    logic [7:0] interrupt_flag_reg;
    logic [7:0] timer_count;
    logic timer_flag;
    logic timer_timeout;
    rit_pkg::rit_acc_s acc;

    wire logic chip_en;
    wire logic port_acc;
    wire logic timer_area;
    wire logic timer_wr;
    wire logic timer_rd;
    wire logic timer_access;
    wire logic edge_ctl_wr;
    wire logic ifr_rd;
    wire logic rd_hit;
    wire logic edge_pol_pos;
    wire logic porta_top_pin;
    wire logic edge_seen;
    wire logic irq_req;

    // chip select and area decode
    assign chip_en = chip_select_hi_i & ~chip_select_lo_n_i;  // see RULE11
    assign acc.sel = !chip_en ? rit_pkg::RIT_SEL_NONE :
                     !ram_io_select_n_i ? rit_pkg::RIT_SEL_RAM :
                     addr_i[rit_pkg::A_TIMER_SEL] ? rit_pkg::RIT_SEL_TIMER :
                     rit_pkg::RIT_SEL_PORT;                   // see RULE20
    assign acc.rd = rw_i;                                     // see RULE4
    assign acc.wr = ~rw_i;                                    // see RULE4
    assign acc.addr = addr_i;

    // register level decode for the port and timer areas
    assign port_acc = (acc.sel == rit_pkg::RIT_SEL_PORT);
    assign timer_area = (acc.sel == rit_pkg::RIT_SEL_TIMER);
    assign timer_wr = timer_area & acc.wr & acc.addr[rit_pkg::A_TIMER_WR];
    assign edge_ctl_wr = timer_area & acc.wr & ~acc.addr[rit_pkg::A_TIMER_WR];
    assign timer_rd = timer_area & acc.rd & ~acc.addr[rit_pkg::A_IFR_SEL];
    assign ifr_rd = timer_area & acc.rd & acc.addr[rit_pkg::A_IFR_SEL];
    assign timer_access = timer_wr | timer_rd;                // see RULE13, RULE15
    assign rd_hit = (acc.sel != rit_pkg::RIT_SEL_NONE) & acc.rd;  // see RULE7

    // flag register image: timer flag bit 7, edge flag bit 6
    always_comb
    begin
        interrupt_flag_reg = 8'h00;
        interrupt_flag_reg[rit_pkg::IFR_TIMER_BIT] = timer_flag;  // see RULE14
        interrupt_flag_reg[rit_pkg::IFR_EDGE_BIT] = edge_flag_r;  // see RULE21
    end

    // read data selection
    always_comb
    begin
        rd_val = 8'h00;
        if (acc.sel == rit_pkg::RIT_SEL_RAM)
            rd_val = mem[acc.addr];
        else if (port_acc && acc.addr[1:0] == rit_pkg::REG_PORTA_OUT)
            rd_val = porta_pins_i;              // see RULE9
        else if (port_acc && acc.addr[1:0] == rit_pkg::REG_PORTA_DIR)
            rd_val = port_a_direction_r;
        else if (port_acc && acc.addr[1:0] == rit_pkg::REG_PORTB_OUT)
            rd_val = port_b_output_r;           // see RULE10
        else if (port_acc && acc.addr[1:0] == rit_pkg::REG_PORTB_DIR)
            rd_val = port_b_direction_r;
        else if (timer_rd)
            rd_val = timer_count;               // see RULE16, RULE18
        else if (ifr_rd)
            rd_val = interrupt_flag_reg;
    end

    // RAM array, written on a RAM write cycle
    always_ff @(posedge clk_i)
    begin
        if (acc.sel == rit_pkg::RIT_SEL_RAM && acc.wr)
            mem[acc.addr] <= data_i;            // see RULE11
    end

    // port direction and output registers
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            port_a_direction_r <= rit_pkg::PORT_RST;  // see RULE1
            port_b_direction_r <= rit_pkg::PORT_RST;
            port_a_output_r <= rit_pkg::PORT_RST;
            port_b_output_r <= rit_pkg::PORT_RST;
        end
        else if (port_acc && acc.wr)
        begin
            if (acc.addr[1:0] == rit_pkg::REG_PORTA_OUT)
                port_a_output_r <= data_i;
            if (acc.addr[1:0] == rit_pkg::REG_PORTA_DIR)
                port_a_direction_r <= data_i;
            if (acc.addr[1:0] == rit_pkg::REG_PORTB_OUT)
                port_b_output_r <= data_i;
            if (acc.addr[1:0] == rit_pkg::REG_PORTB_DIR)
                port_b_direction_r <= data_i;
        end
    end

    // interrupt enables and edge polarity
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            timer_irq_enable_r <= 1'b0;         // see RULE2
            edge_irq_enable_r <= 1'b0;          // see RULE22
            edge_pos_r <= 1'b0;                 // see RULE22
        end
        else
        begin
            if (timer_access)
                timer_irq_enable_r <= acc.addr[rit_pkg::A_TIRQ_EN];  // see RULE13
            if (edge_ctl_wr)
            begin
                edge_irq_enable_r <= acc.addr[rit_pkg::A_EDGE_EN];
                edge_pos_r <= acc.addr[rit_pkg::A_EDGE_POS];
            end
        end
    end

    // top pin edge detect; reset forces falling edge, not flag clearing
    assign porta_top_pin = porta_pins_i[7];       // see RULE19
    assign edge_pol_pos = rst_n_i & edge_pos_r;
    assign edge_seen = edge_pol_pos ? (~porta_top_prev_r & porta_top_pin)
                                    : (porta_top_prev_r & ~porta_top_pin);  // see RULE6

    always_ff @(posedge clk_i)
    begin
        porta_top_prev_r <= porta_top_pin;
    end

    // edge flag: set wins over the flag register read clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            edge_flag_r <= edge_seen;           // see RULE22
        else if (edge_seen)
            edge_flag_r <= 1'b1;
        else if (ifr_rd)
            edge_flag_r <= 1'b0;                // see RULE21
    end

    // read answer, driven in the cycle after the addressed read
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            data_r <= 8'h00;
            data_oe_r <= 1'b0;                  // see RULE2
        end
        else
        begin
            data_oe_r <= rd_hit;                // see RULE7
            if (rd_hit)
                data_r <= rd_val;               // see RULE4
        end
    end

    rit_timer #(
        .COUNT_W(rit_pkg::DATA_W)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(timer_wr),
        .load_val_i(data_i),
        .presc_sel_i(acc.addr[1:0]),
        .access_i(timer_access),
        .count_o(timer_count),
        .flag_o(timer_flag),
        .timeout_o(timer_timeout)
    );

    // open drain request: pulled low only for an enabled, pending source
    assign irq_req = rst_n_i & ((timer_flag & timer_irq_enable_r)
                   | (edge_flag_r & edge_irq_enable_r));  // see RULE5, RULE6
    assign irq_o = 1'b0;
    assign irq_oe_o = irq_req;                  // see RULE5

    // data bus and port pins
    assign data_o = data_r;
    assign data_oe_o = data_oe_r & rst_n_i;     // see RULE2, RULE7
    assign porta_pins_o = port_a_output_r;      // see RULE8
    assign portb_pins_o = port_b_output_r;      // see RULE8
    assign porta_oe_o = port_a_direction_r & {8{rst_n_i}};  // see RULE1, RULE8
    assign portb_oe_o = port_b_direction_r & {8{rst_n_i}};  // see RULE1, RULE8

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_port_rd(logic [1:0] reg_sel);
        port_acc && acc.rd && acc.addr[1:0] == reg_sel;
    endsequence

    sequence s_port_wr(logic [1:0] reg_sel);
        port_acc && acc.wr && acc.addr[1:0] == reg_sel;
    endsequence

    sequence s_ram_wr;
        acc.sel == rit_pkg::RIT_SEL_RAM && acc.wr;
    endsequence

    // state of ports, bus and interrupt logic right after reset
    AST_RESET_PORTS: assert property ($rose(rst_n_i) |-> porta_oe_o == 8'h00 // see RULE1
        && portb_oe_o == 8'h00 && portb_pins_o == 8'h00)
        else $error("ports not cleared by reset");
    AST_RESET_IRQ: assert property ($rose(rst_n_i) |-> !irq_oe_o && !data_oe_o) // see RULE2
        else $error("irq or data bus active after reset");
    AST_RESET_EDGE: assert property ($rose(rst_n_i) |-> // see RULE22
        !edge_pos_r && !edge_irq_enable_r)
        else $error("edge detect not back to disabled falling edge");

    // bus answer timing and read data
    AST_BUS_DRIVE: assert property (data_oe_o |-> $past(rd_hit)) // see RULE7
        else $error("data bus driven without addressed read");
    AST_BUS_ANSWER: assert property (rd_hit |=> data_oe_o) // see RULE7
        else $error("read answer timing wrong");
    AST_PORTA_PINS: assert property (s_port_rd(rit_pkg::REG_PORTA_OUT) |=> // see RULE9
        data_o == $past(porta_pins_i))
        else $error("port A read did not return pins");
    AST_PORTB_REG: assert property (s_port_rd(rit_pkg::REG_PORTB_OUT) |=> // see RULE10
        data_o == portb_pins_o)
        else $error("port B read did not return output register");
    AST_TIMER_READ: assert property (timer_rd |=> data_o == $past(timer_count)) // see RULE16
        else $error("timer read did not return the count");
    AST_IFR_READ: assert property (ifr_rd |=> // see RULE14, RULE21
        data_o == {$past(timer_flag), $past(edge_flag_r), 6'h00})
        else $error("flag register read wrong");
    AST_RAM_RW: assert property (s_ram_wr ##1 // see RULE11
        acc.sel == rit_pkg::RIT_SEL_RAM && acc.rd && acc.addr == $past(acc.addr)
        |=> data_o == $past(data_i, 2))
        else $error("RAM read did not return written byte");

    // register writes and interrupt control
    AST_PORTB_WR: assert property (s_port_wr(rit_pkg::REG_PORTB_OUT) |=> // see RULE8
        portb_pins_o == $past(data_i))
        else $error("port B output write not on pins");
    AST_DIR_WR: assert property (s_port_wr(rit_pkg::REG_PORTA_DIR) |=> // see RULE8
        porta_oe_o == $past(data_i))
        else $error("port A direction write not on enables");
    AST_RAM_ISOLATE: assert property (s_ram_wr |=> // see RULE20
        $stable(portb_pins_o) && $stable(porta_oe_o))
        else $error("RAM write touched port registers");
    AST_TIRQ_LATCH: assert property (timer_access |=> // see RULE13
        timer_irq_enable_r == $past(addr_i[3]))
        else $error("timer enable not latched from address line three");
    AST_TIRQ_GATE: assert property (timer_flag && !timer_irq_enable_r && !edge_flag_r // see RULE5
        |-> !irq_oe_o)
        else $error("disabled timer flag pulled the request");
    AST_TIMER_IRQ: assert property (timer_timeout && timer_irq_enable_r // see RULE5, RULE6
        && !timer_access |=> irq_oe_o)
        else $error("enabled timeout did not pull the request");
    AST_EDGE_SET: assert property (edge_seen |=> edge_flag_r) // see RULE6
        else $error("top pin edge did not set the edge flag");
    AST_EDGE_IRQ: assert property (edge_seen && edge_irq_enable_r && !edge_ctl_wr // see RULE6
        |=> irq_oe_o)
        else $error("enabled edge did not pull the request");
    AST_EDGE_CLR: assert property (ifr_rd && !edge_seen |=> !edge_flag_r) // see RULE21
        else $error("flag register read did not clear edge flag");

endmodule

// ---- hdl/rit_pkg.sv ----
package rit_pkg;

    // bus and memory geometry
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int RAM_DEPTH = 128;
    localparam int PRESC_W = 10;

    // address line positions used by the decoder
    localparam int A_TIMER_SEL = 2;
    localparam int A_TIRQ_EN = 3;
    localparam int A_TIMER_WR = 4;
    localparam int A_EDGE_EN = 1;
    localparam int A_EDGE_POS = 0;
    localparam int A_IFR_SEL = 0;

    // port register select on address lines 1..0
    localparam logic [1:0] REG_PORTA_OUT = 2'h0;
    localparam logic [1:0] REG_PORTA_DIR = 2'h1;
    localparam logic [1:0] REG_PORTB_OUT = 2'h2;
    localparam logic [1:0] REG_PORTB_DIR = 2'h3;

    // prescale select on address lines 1..0
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV8 = 2'h1;
    localparam logic [1:0] PRE_DIV64 = 2'h2;
    localparam logic [1:0] PRE_DIV1024 = 2'h3;

    // last prescaler count of each interval
    localparam logic [9:0] PRESC_LIM1 = 10'h000;
    localparam logic [9:0] PRESC_LIM8 = 10'h007;
    localparam logic [9:0] PRESC_LIM64 = 10'h03F;
    localparam logic [9:0] PRESC_LIM1024 = 10'h3FF;

    // interrupt flag register layout
    localparam int IFR_TIMER_BIT = 7;
    localparam int IFR_EDGE_BIT = 6;

    // reset values
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] TIMER_RST = 8'hFF;
    localparam logic [1:0] PRESC_RST = 2'h3;
    localparam logic [9:0] PRESC_CNT_RST = 10'h000;

    // target of a bus cycle
    typedef enum logic [1:0] {
        RIT_SEL_NONE = 2'b00,
        RIT_SEL_RAM = 2'b01,
        RIT_SEL_PORT = 2'b10,
        RIT_SEL_TIMER = 2'b11
    } rit_sel_e;

    // one decoded bus cycle
    typedef struct packed {
        rit_sel_e sel;
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
    } rit_acc_s;

    // prescaler terminal count for a select code
    function automatic logic [9:0] presc_limit(input logic [1:0] sel);
        logic [9:0] lim;
        lim = PRESC_LIM1;
        if (sel == PRE_DIV8)
            lim = PRESC_LIM8;
        else if (sel == PRE_DIV64)
            lim = PRESC_LIM64;
        else if (sel == PRE_DIV1024)
            lim = PRESC_LIM1024;
        return lim;
    endfunction

endpackage

// ---- hdl/rit_timer.sv ----
`timescale 1ns/1ps
module rit_timer #(
    parameter int COUNT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [COUNT_W-1:0] load_val_i,
    input wire logic [1:0] presc_sel_i,
    input wire logic access_i,
    output logic [COUNT_W-1:0] count_o,
    output logic flag_o,
    output logic timeout_o
);
    logic [rit_pkg::PRESC_W-1:0] presc_r;
    logic [COUNT_W-1:0] count_r;
    logic [1:0] sel_r;
    logic expired_r;
    logic flag_r;
    wire logic presc_end;
    wire logic at_zero;
    wire logic step;
    wire logic [COUNT_W-1:0] one_c = {{(COUNT_W-1){1'b0}}, 1'b1};

    // a step is one prescale interval, or one clock once at zero or expired
    assign presc_end = (presc_r == rit_pkg::presc_limit(sel_r));
    assign at_zero = (count_r == '0);
    assign step = presc_end | at_zero | expired_r;  // see RULE17
    assign timeout_o = step & at_zero;              // see RULE17
    assign count_o = count_r;
    assign flag_o = flag_r;

    // counter and prescaler; a load restarts the interval at the write
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            count_r <= rit_pkg::TIMER_RST;
            sel_r <= rit_pkg::PRESC_RST;
            presc_r <= rit_pkg::PRESC_CNT_RST;
            expired_r <= 1'b0;
        end
        else if (load_i)
        begin
            count_r <= load_val_i;              // see RULE12
            sel_r <= presc_sel_i;               // see RULE12
            presc_r <= rit_pkg::PRESC_CNT_RST;  // see RULE23
            expired_r <= 1'b0;
        end
        else
        begin
            presc_r <= presc_end ? rit_pkg::PRESC_CNT_RST : presc_r + 10'h001;  // see RULE16
            if (step)
                count_r <= count_r - one_c;     // see RULE16, RULE17, RULE18
            if (timeout_o)
                expired_r <= 1'b1;              // see RULE18
        end
    end

    // flag: timeout sets it, any timer access clears it, set wins
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            flag_r <= 1'b0;
        else if (timeout_o)
            flag_r <= 1'b1;                     // see RULE14, RULE15
        else if (access_i)
            flag_r <= 1'b0;                     // see RULE15
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_load_div8;
        load_i && presc_sel_i == 2'h1 && load_val_i > 8'h01;
    endsequence

    sequence s_quiet7;
        (!load_i)[*7];
    endsequence

    AST_DIV8_STEP: assert property (s_load_div8 ##1 s_quiet7 ##1 !load_i |=> // see RULE12
        count_o == $past(count_o) - 8'h01)
        else $error("divide by 8 step not after 8 clocks");
    AST_DIV8_HOLD: assert property (s_load_div8 ##1 s_quiet7 |-> // see RULE16
        count_o == $past(load_val_i, 7))
        else $error("count moved early in divide by 8");
    AST_WRAP: assert property (timeout_o && !load_i |=> count_o == 8'hFF) // see RULE17
        else $error("counter did not wrap to all ones");
    AST_FAST_AFTER: assert property (expired_r && !load_i |=> // see RULE18
        count_o == $past(count_o) - 8'h01)
        else $error("expired counter not decrementing every clock");
    AST_FLAG_SET: assert property (timeout_o |=> flag_o) // see RULE14
        else $error("timeout did not set flag");
    AST_FLAG_CLR: assert property (access_i && !timeout_o |=> !flag_o) // see RULE15
        else $error("timer access did not clear flag");

endmodule

// ---- verif/rit_pins_model.sv ----
`timescale 1ns/1ps
module rit_pins_model (
    input wire logic [7:0] porta_pins_o,
    input wire logic [7:0] porta_oe_o,
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    output logic [7:0] porta_pins_i
);
    // pin level: device drive, else outside driver, else the pull-up
    always_comb
    begin
        for (int b = 0; b < 8; b++)
        begin
            if (porta_oe_o[b])
                porta_pins_i[b] = porta_pins_o[b];
            else if (ext_en_i[b])
                porta_pins_i[b] = ext_val_i[b];
            else
                porta_pins_i[b] = 1'b1; // released input floats high
        end
    end
endmodule

// ---- verif/ram_io_interval_timer_test.sv ----
`timescale 1ns/1ps
module ram_io_interval_timer_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rw_i = 1'b1;
    logic [6:0] addr_i = 7'h00;
    logic ram_io_select_n_i = 1'b1;
    logic chip_select_hi_i = 1'b0;
    logic chip_select_lo_n_i = 1'b1;
    logic [7:0] data_i = 8'h00;
    logic [7:0] data_o, porta_pins_i, porta_pins_o, porta_oe_o, portb_pins_o, portb_oe_o;
    logic data_oe_o, irq_o, irq_oe_o;
    logic [7:0] ext_val = 8'hFF;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] rd;
    logic [7:0] rd2;
    int num_errors = 0;
    int tests_run = 0;

    // free running system clock
    always #5 clk_i = ~clk_i;

    rit_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rw_i(rw_i), .addr_i(addr_i),
        .ram_io_select_n_i(ram_io_select_n_i), .chip_select_hi_i(chip_select_hi_i),
        .chip_select_lo_n_i(chip_select_lo_n_i), .data_i(data_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
        .porta_pins_i(porta_pins_i), .porta_pins_o(porta_pins_o), .porta_oe_o(porta_oe_o),
        .portb_pins_o(portb_pins_o), .portb_oe_o(portb_oe_o));

    rit_pins_model pins (.porta_pins_o(porta_pins_o), .porta_oe_o(porta_oe_o),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .porta_pins_i(porta_pins_i));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one selected cycle: driven after the falling edge, taken at the rising edge
    task automatic bus(input logic rw, input logic rs_n, input logic [6:0] a, input logic [7:0] d);
        rw_i = rw;
        ram_io_select_n_i = rs_n;
        addr_i = a;
        data_i = d;
        chip_select_hi_i = 1'b1;
        chip_select_lo_n_i = 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        rd = data_o;
        chk("data drive", {7'h00, data_oe_o}, {7'h00, rw});
    endtask

    // unselected write cycle, must be ignored and never drive the bus
    task automatic idle();
        chip_select_hi_i = 1'b0;
        rw_i = 1'b0;
        data_i = 8'h00;
        @(posedge clk_i);
        @(negedge clk_i);
        chk("idle drive", {7'h00, data_oe_o}, 8'h00);
    endtask

    task automatic t_reset();
        repeat (2) @(negedge clk_i);
        chk("bus drive in reset", {7'h00, data_oe_o}, 8'h00);
        chk("irq in reset", {7'h00, irq_oe_o}, 8'h00);
        chk("port a oe in reset", porta_oe_o, 8'h00);
        chk("port b oe in reset", portb_oe_o, 8'h00);
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1; // held four cycles
        bus(1'b1, 1'b1, 7'h01, 8'h00);
        chk("port a dir", rd, 8'h00);
        bus(1'b1, 1'b1, 7'h03, 8'h00);
        chk("port b dir", rd, 8'h00);
        bus(1'b1, 1'b1, 7'h02, 8'h00);
        chk("port b out", rd, 8'h00);
        chk("port a out", porta_pins_o, 8'h00);
    endtask

    task automatic t_ports();
        bus(1'b0, 1'b1, 7'h00, 8'hA5);
        bus(1'b0, 1'b1, 7'h01, 8'hF0);
        ext_en = 8'hFF;
        ext_val = 8'h3C;
        bus(1'b1, 1'b1, 7'h00, 8'h00);
        chk("port a pins", rd, 8'hAC);
        chk("port a oe", porta_oe_o, 8'hF0);
        bus(1'b0, 1'b1, 7'h02, 8'h5A);
        bus(1'b0, 1'b1, 7'h03, 8'h0F);
        bus(1'b1, 1'b1, 7'h02, 8'h00);
        chk("port b read", rd, 8'h5A);
        chk("port b pins", portb_pins_o, 8'h5A);
        chk("port b oe", portb_oe_o, 8'h0F);
        ext_en = 8'h00;
    endtask

    task automatic t_ram();
        bus(1'b0, 1'b0, 7'h00, 8'h11);
        bus(1'b0, 1'b0, 7'h7F, 8'hEE);
        bus(1'b0, 1'b1, 7'h02, 8'h77);
        idle();
        bus(1'b1, 1'b0, 7'h7F, 8'h00);
        chk("ram top", rd, 8'hEE);
        bus(1'b1, 1'b0, 7'h00, 8'h00);
        chk("ram bottom", rd, 8'h11);
        bus(1'b0, 1'b0, 7'h40, 8'h5C);
        bus(1'b1, 1'b0, 7'h40, 8'h00);
        chk("ram write then read", rd, 8'h5C);
    endtask

    task automatic t_timer_steps();
        int lim;
        int k;
        for (int p = 0; p < 4; p++)
        begin
            lim = (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 1024;
            bus(1'b0, 1'b1, 7'h1C | 7'(p), 8'h01);
            k = 0;
            while (irq_oe_o !== 1'b1 && k < 1100)
            begin
                idle();
                k++;
            end
            chk("timeout cycles", 8'(k - lim), 8'h01);
        end
    endtask

    task automatic t_timer_read();
        bus(1'b0, 1'b1, 7'h15, 8'h05);
        repeat (11) idle();
        bus(1'b1, 1'b1, 7'h04, 8'h00);
        chk("count mid interval", rd, 8'h04);
        repeat (40) idle();
        chk("irq blocked", {7'h00, irq_oe_o}, 8'h00);
        bus(1'b1, 1'b1, 7'h05, 8'h00);
        chk("flag register", rd, 8'h80);
        bus(1'b1, 1'b1, 7'h04, 8'h00);
        rd2 = rd;
        bus(1'b1, 1'b1, 7'h04, 8'h00);
        chk("step per clock", 8'(rd2 - rd), 8'h01);
        bus(1'b1, 1'b1, 7'h05, 8'h00);
        chk("flag cleared", rd, 8'h00);
        // reads latch the enable; the third read meets the timeout edge
        bus(1'b0, 1'b1, 7'h14, 8'h02);
        repeat (3) bus(1'b1, 1'b1, 7'h0C, 8'h00);
        chk("set wins", {7'h00, irq_oe_o}, 8'h01);
        bus(1'b1, 1'b1, 7'h04, 8'h00);
        chk("irq released", {7'h00, irq_oe_o}, 8'h00);
    endtask

    task automatic t_edge();
        bus(1'b0, 1'b1, 7'h14, 8'hFF);
        bus(1'b0, 1'b1, 7'h01, 8'h00);
        bus(1'b1, 1'b1, 7'h05, 8'h00);
        ext_en = 8'h80;
        ext_val = 8'h00;
        idle();
        idle();
        chk("edge irq off", {7'h00, irq_oe_o}, 8'h00);
        bus(1'b1, 1'b1, 7'h05, 8'h00);
        chk("falling flag", rd, 8'h40);
        bus(1'b1, 1'b1, 7'h05, 8'h00);
        chk("edge flag cleared", rd, 8'h00);
        bus(1'b0, 1'b1, 7'h07, 8'h00);
        ext_val = 8'h80;
        idle();
        idle();
        chk("edge irq", {7'h00, irq_oe_o}, 8'h01);
        chk("irq level", {7'h00, irq_o}, 8'h00);
        bus(1'b1, 1'b1, 7'h05, 8'h00);
        chk("rising flag", rd, 8'h40);
        chk("edge irq clear", {7'h00, irq_oe_o}, 8'h00);
        ext_en = 8'h00;
    endtask

    // reset in mid run: ports cleared, a falling top pin edge still flags
    task automatic t_mid_reset();
        bus(1'b0, 1'b1, 7'h03, 8'hFF);
        ext_en = 8'h80;
        ext_val = 8'h80;
        rst_n_i = 1'b0;
        idle();
        idle();
        ext_val = 8'h00;
        idle();
        chk("irq in mid reset", {7'h00, irq_oe_o}, 8'h00);
        chk("port b oe in mid reset", portb_oe_o, 8'h00);
        rst_n_i = 1'b1; // held three cycles
        bus(1'b1, 1'b1, 7'h05, 8'h00);
        chk("edge flag from reset", rd, 8'h40);
        bus(1'b1, 1'b1, 7'h03, 8'h00);
        chk("port b dir after reset", rd, 8'h00);
        ext_en = 8'h00;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        t_reset();
        t_ports();
        t_ram();
        t_timer_steps();
        t_timer_read();
        t_edge();
        t_mid_reset();
        complete_run();
    end

    // watchdog, well beyond the longest prescale wait
    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
endmodule
